/* cpu_host_access_port_cfg.svh */
// Purpose: Constants for the host access port: direct addresses, bit positions, reset values.
// Assumes: Included once per compilation unit by bare name.
// Notes:   Types live in cpu_host_access_port_pkg.
`ifndef CPU_HOST_ACCESS_PORT_CFG_SVH
`define CPU_HOST_ACCESS_PORT_CFG_SVH

// Direct addresses
`define HAP_ADDR_IDX_LO   3'h0
`define HAP_ADDR_IDX_HI   3'h1
`define HAP_ADDR_DATA     3'h2
`define HAP_ADDR_FRAME    3'h3
`define HAP_ADDR_CMD      3'h4
`define HAP_ADDR_IRQ      3'h5
`define HAP_ADDR_CBUF1    3'h6
`define HAP_ADDR_CBUF2    3'h7

// Command bits, host write to the command/status location
`define HAP_CMD_CRX_READY 0
`define HAP_CMD_CTX1_REL  1
`define HAP_CMD_CTX2_REL  2
`define HAP_CMD_TXF_DONE  3
`define HAP_CMD_RXF_EOF   4
`define HAP_CMD_REALIGN   5

// Interrupt source bits
`define HAP_IRQ_FRAME     0
`define HAP_IRQ_CF1       1
`define HAP_IRQ_CF2       2
`define HAP_IRQ_TIMEOUT   7

// Reset values and counts
`define HAP_IDX_RST       16'h0000
`define HAP_DATA_RST      16'h0000
`define HAP_BYTE_CNT_RST  4'h0
`define HAP_HDR_BYTES     4'h8
`define HAP_BYTES_WIDE    4'h2
`define HAP_BYTES_NARROW  4'h1

`endif

/* cpu_host_access_port_pkg.sv */
// Purpose: Types shared by the host access port and its users.
// Assumes: None.
// Notes:   Frame words toward the receive FIFO travel as one struct.
package cpu_host_access_port_pkg;

    // Host request captured from the parallel pins
    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
    } host_req_t;

    // One word written by the host toward the receive FIFO
    typedef struct packed {
        logic [15:0] data;
        logic        wide;
        logic        hdr;
        logic        eof;
    } rxf_word_t;

    // Indirect register access toward the switch core
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } ind_req_t;

endpackage : cpu_host_access_port_pkg

/* cpu_host_access_port.sv */
// Purpose: Host CPU access port: eight direct locations giving indirect register access,
//          frame FIFO access, control command buffers, command/status and interrupt sources.
// Assumes: Host pins are asynchronous to i_clk and held stable for at least four clocks per strobe;
//          indirect read data from the core is valid combinationally for the current index.
// Notes:   Reads latch o_rdata at strobe assertion; side effects are one-cycle pulses.
//
// Functional notes
// - Location 0 write-only index, width by mode
// - Location 1 index high byte, 8-bit only
// - Location 2 moves indirect register data byte
// - Frames: 8-byte header, data 8-byte multiples
// - Command bit 0 marks control frame ready
// - Command bits 1/2 release transmit buffers
// - Command bit 3 ends frame, flushes fragment
// - Command bit 4 marks next write EOF
// - Status bits 1/2 show buffer readiness
// - Status bits 3/4/5 show FIFO conditions
// - Location 5 bits 0-2 sources, 6:3 reserved
// - Bit 7 timeout sticky, host writes 0
// - Location 6: write receive, read transmit 1
// - Location 7 reads transmit buffer 2
`include "cpu_host_access_port_cfg.svh"

module cpu_host_access_port
    import cpu_host_access_port_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    // Host pins (asynchronous)
    input  wire logic              i_mode_8bit,
    input  wire logic              i_cs_n,
    input  wire logic              i_wr_n,
    input  wire logic              i_rd_n,
    input  wire logic [2:0]        i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic [DATA_W-1:0]      o_rdata,
    // Indirect register space
    output ind_req_t               o_ind,
    input  wire logic [7:0]        i_ind_rdata,
    // Transmit FIFO, switch toward host
    input  wire logic [15:0]       i_txf_data,
    input  wire logic              i_txf_has_data,
    input  wire logic              i_txf_eof,
    output logic                   o_txf_pop,
    output logic                   o_txf_done,
    // Receive FIFO, host toward switch
    input  wire logic              i_rxf_space_ok,
    output rxf_word_t              o_rxf_word,
    output logic                   o_rxf_valid,
    output logic                   o_realign,
    // Control command buffers
    input  wire logic              i_crx_free,
    output logic [15:0]            o_crx_wdata,
    output logic                   o_crx_we,
    output logic                   o_crx_ready,
    input  wire logic              i_ctx1_avail,
    input  wire logic              i_ctx2_avail,
    input  wire logic [15:0]       i_ctx1_data,
    input  wire logic [15:0]       i_ctx2_data,
    output logic                   o_ctx1_pop,
    output logic                   o_ctx2_pop,
    output logic                   o_ctx1_release,
    output logic                   o_ctx2_release,
    // Interrupt sources from the core
    input  wire logic              i_irq_frame,
    input  wire logic              i_irq_cf1,
    input  wire logic              i_irq_cf2,
    input  wire logic              i_timeout_evt
);

    if (DATA_W != 16) begin : g_width_check
        $error("cpu_host_access_port: DATA_W must be 16");
    end

    // Two-flop synchronisers on every host pin
    logic [2:0]        strb_s1_q;
    logic [2:0]        strb_s2_q;
    logic [2:0]        strb_s3_q;
    logic              mode_s1_q;
    logic              mode_s2_q;
    host_req_t         req_s1_q;
    host_req_t         req_s2_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            strb_s1_q <= 3'h7;
            strb_s2_q <= 3'h7;
            strb_s3_q <= 3'h7;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            req_s1_q  <= '0;
            req_s2_q  <= '0;
        end else begin
            strb_s1_q <= {i_cs_n, i_wr_n, i_rd_n};
            strb_s2_q <= strb_s1_q;
            strb_s3_q <= strb_s2_q;
            mode_s1_q <= i_mode_8bit;
            mode_s2_q <= mode_s1_q;
            req_s1_q  <= '{addr: i_addr, wdata: i_wdata};
            req_s2_q  <= req_s1_q;
        end
    end

    // Strobe assertion edges, qualified by chip select
    wire logic sel_now  = !strb_s2_q[2];
    wire logic wr_evt   = sel_now && !strb_s2_q[1] && strb_s3_q[1];
    wire logic rd_evt   = sel_now && !strb_s2_q[0] && strb_s3_q[0];
    wire logic [2:0]  a = req_s2_q.addr;
    wire logic [15:0] wd = req_s2_q.wdata;
    wire logic narrow   = mode_s2_q;

    wire logic wr_idx_lo = wr_evt && (a == `HAP_ADDR_IDX_LO);
    wire logic wr_idx_hi = wr_evt && (a == `HAP_ADDR_IDX_HI) && narrow;
    wire logic wr_data   = wr_evt && (a == `HAP_ADDR_DATA);
    wire logic wr_frame  = wr_evt && (a == `HAP_ADDR_FRAME);
    wire logic wr_cmd    = wr_evt && (a == `HAP_ADDR_CMD);
    wire logic wr_irq    = wr_evt && (a == `HAP_ADDR_IRQ);
    wire logic wr_cbuf1  = wr_evt && (a == `HAP_ADDR_CBUF1);
    wire logic rd_data   = rd_evt && (a == `HAP_ADDR_DATA);
    wire logic rd_frame  = rd_evt && (a == `HAP_ADDR_FRAME);
    wire logic rd_cbuf1  = rd_evt && (a == `HAP_ADDR_CBUF1);
    wire logic rd_cbuf2  = rd_evt && (a == `HAP_ADDR_CBUF2);

    // Indirect index
    logic [15:0] idx_q;
    logic [15:0] idx_d;

    always_comb begin
        idx_d = idx_q;
        if (wr_idx_lo && narrow) begin
            idx_d[7:0] = wd[7:0];
        end else if (wr_idx_lo) begin
            idx_d = wd;
        end
        if (wr_idx_hi) begin
            idx_d[15:8] = wd[7:0];
        end
    end

    // Command bits are one-cycle pulses: they clear themselves the next clock
    wire logic [7:0] cmd = wd[7:0];
    wire logic cmd_crx   = wr_cmd && cmd[`HAP_CMD_CRX_READY];
    wire logic cmd_rel1  = wr_cmd && cmd[`HAP_CMD_CTX1_REL];
    wire logic cmd_rel2  = wr_cmd && cmd[`HAP_CMD_CTX2_REL];
    wire logic cmd_done  = wr_cmd && cmd[`HAP_CMD_TXF_DONE];
    wire logic cmd_eof   = wr_cmd && cmd[`HAP_CMD_RXF_EOF];
    wire logic cmd_align = wr_cmd && cmd[`HAP_CMD_REALIGN];

    // End-of-frame arm for the next receive FIFO write
    logic eof_arm_q;
    logic eof_arm_d;
    assign eof_arm_d = cmd_eof ? 1'b1 : (wr_frame || cmd_align) ? 1'b0 : eof_arm_q;

    // Byte count inside the current host frame; first bytes form the status header
    logic [3:0] bcnt_q;
    logic [3:0] bcnt_d;
    wire logic [3:0] step    = narrow ? `HAP_BYTES_NARROW : `HAP_BYTES_WIDE;
    wire logic       in_hdr  = bcnt_q < `HAP_HDR_BYTES;
    wire logic [3:0] bcnt_up = in_hdr ? 4'(bcnt_q + step) : bcnt_q;

    always_comb begin
        bcnt_d = bcnt_q;
        if (cmd_align) begin
            bcnt_d = `HAP_BYTE_CNT_RST;
        end else if (wr_frame && eof_arm_q) begin
            bcnt_d = `HAP_BYTE_CNT_RST;
        end else if (wr_frame) begin
            bcnt_d = bcnt_up;
        end
    end

    // Timeout flag: sticky, cleared only by writing 0; a new event wins over the clear
    logic tmo_q;
    logic tmo_d;
    wire logic tmo_clr = wr_irq && !wd[`HAP_IRQ_TIMEOUT];
    assign tmo_d = i_timeout_evt ? 1'b1 : tmo_clr ? 1'b0 : tmo_q;

    // Read views
    wire logic [7:0] status_view = {2'b00,
                                    i_txf_eof,
                                    i_rxf_space_ok,
                                    i_txf_has_data,
                                    i_ctx2_avail,
                                    i_ctx1_avail,
                                    i_crx_free};
    wire logic [7:0] irq_view = {tmo_q, 4'h0, i_irq_cf2, i_irq_cf1, i_irq_frame};

    logic [15:0] rmux;
    always_comb begin
        case (a)
            `HAP_ADDR_DATA:  rmux = {8'h00, i_ind_rdata};
            `HAP_ADDR_FRAME: rmux = i_txf_data;
            `HAP_ADDR_CMD:   rmux = {8'h00, status_view};
            `HAP_ADDR_IRQ:   rmux = {8'h00, irq_view};
            `HAP_ADDR_CBUF1: rmux = i_ctx1_data;
            `HAP_ADDR_CBUF2: rmux = i_ctx2_data;
            default:         rmux = `HAP_DATA_RST; // Index locations are write-only
        endcase
    end
    wire logic [15:0] rdata_d = narrow ? {8'h00, rmux[7:0]} : rmux;

    // Word toward the receive FIFO
    wire rxf_word_t rxf_d = '{data: narrow ? {8'h00, wd[7:0]} : wd,
                              wide: !narrow,
                              hdr:  in_hdr,
                              eof:  eof_arm_q};

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            idx_q     <= `HAP_IDX_RST;
            eof_arm_q <= 1'b0;
            bcnt_q    <= `HAP_BYTE_CNT_RST;
            tmo_q     <= 1'b0;
        end else begin
            idx_q     <= idx_d;
            eof_arm_q <= eof_arm_d;
            bcnt_q    <= bcnt_d;
            tmo_q     <= tmo_d;
        end
    end

    // Registered outputs: read data and indirect access
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= '0;
            o_ind   <= '0;
        end else begin
            if (rd_evt) begin
                o_rdata <= rdata_d;
            end
            o_ind.addr <= idx_d;
            if (wr_data) begin
                o_ind.wdata <= wd[7:0];
            end
            o_ind.wr <= wr_data;
            o_ind.rd <= rd_data;
        end
    end

    // Registered outputs: frame FIFOs
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rxf_word  <= '0;
            o_rxf_valid <= 1'b0;
            o_txf_pop   <= 1'b0;
            o_txf_done  <= 1'b0;
            o_realign   <= 1'b0;
        end else begin
            if (wr_frame) begin
                o_rxf_word <= rxf_d;
            end
            o_rxf_valid <= wr_frame;
            o_txf_pop   <= rd_frame;
            o_txf_done  <= cmd_done;
            o_realign   <= cmd_align;
        end
    end

    // Registered outputs: control command buffers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_crx_wdata    <= '0;
            o_crx_we       <= 1'b0;
            o_crx_ready    <= 1'b0;
            o_ctx1_pop     <= 1'b0;
            o_ctx2_pop     <= 1'b0;
            o_ctx1_release <= 1'b0;
            o_ctx2_release <= 1'b0;
        end else begin
            if (wr_cbuf1) begin
                o_crx_wdata <= narrow ? {8'h00, wd[7:0]} : wd;
            end
            o_crx_we       <= wr_cbuf1;
            o_crx_ready    <= cmd_crx;
            o_ctx1_pop     <= rd_cbuf1;
            o_ctx2_pop     <= rd_cbuf2;
            o_ctx1_release <= cmd_rel1;
            o_ctx2_release <= cmd_rel2;
        end
    end

endmodule : cpu_host_access_port

/* cpu_host_access_port_props.sv */
// Purpose: Port-level assertions for the host access port.
// Assumes: Host strobes stay low for at least five clocks.
// Notes:   Bound to the design from the bench top file.
module cpu_host_access_port_props
    import cpu_host_access_port_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_mode_8bit,
    input wire logic        i_cs_n,
    input wire logic        i_wr_n,
    input wire logic        i_rd_n,
    input wire logic [2:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire ind_req_t    o_ind,
    input wire logic        o_rxf_valid,
    input wire logic        o_crx_we,
    input wire logic        o_crx_ready,
    input wire logic        o_txf_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence wr_ev(logic [2:0] a);
        $fell(i_wr_n) && !i_cs_n && i_addr == a;
    endsequence

    sequence rd_ev(logic [2:0] a);
        $fell(i_rd_n) && !i_cs_n && i_addr == a;
    endsequence

    chk_idx_load: assert property (wr_ev(3'h0) ##0 !i_mode_8bit |->
        ##4 o_ind.addr == $past(i_wdata, 4)) else $error("index not loaded");
    chk_idx_unread: assert property (rd_ev(3'h0) |-> ##4 o_rdata == '0)
        else $error("index location readable");
    chk_ind_wr: assert property (wr_ev(3'h2) |-> ##[2:4] o_ind.wr ##1 !o_ind.wr)
        else $error("indirect write pulse wrong");
    chk_ind_rd: assert property (rd_ev(3'h2) |-> ##[2:4] o_ind.rd ##1 !o_ind.rd)
        else $error("indirect read pulse wrong");
    chk_frame_push: assert property (wr_ev(3'h3) |-> ##[2:4] o_rxf_valid ##1 !o_rxf_valid)
        else $error("frame word pulse wrong");
    chk_crx_ready: assert property (wr_ev(3'h4) ##0 i_wdata[0] |-> ##[2:4] o_crx_ready)
        else $error("receive buffer ready missing");
    chk_txf_done: assert property (wr_ev(3'h4) ##0 i_wdata[3] |-> ##[2:4] o_txf_done)
        else $error("frame done missing");
    chk_irq_rsvd: assert property (rd_ev(3'h5) |-> ##4 o_rdata[6:3] == 4'h0)
        else $error("reserved interrupt bits set");
    chk_no_wr7: assert property (wr_ev(3'h7) |-> ##1 (!o_crx_we && !o_rxf_valid)[*6])
        else $error("write to location 7 acted");
endmodule : cpu_host_access_port_props

/* host_cpu_model.sv */
// Purpose: Host processor model driving the parallel pins.
// Assumes: Strobe low six clocks, high six clocks between accesses.
// Notes:   Released address and data lines show the inverse of the last value.
module host_cpu_model (
    input  wire logic [0:0]  i_clk,
    input  wire logic [15:0] i_rdata,
    output logic             o_cs_n,
    output logic             o_wr_n,
    output logic             o_rd_n,
    output logic [2:0]       o_addr,
    output logic [15:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_addr = 3'h0;
        o_wdata = 16'h0000;
    end

    task automatic acc(input logic wr, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge i_clk);
        #1;
        o_cs_n = 1'b0;
        o_wr_n = !wr;
        o_rd_n = wr;
        o_addr = a;
        o_wdata = (a == 3'h4) ? {d[15:8], 2'b00, d[5:0]} : d;
        repeat (6) @(posedge i_clk);
        #1;
        q = i_rdata;
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
        repeat (5) @(posedge i_clk);
        #1;
    endtask : acc
endmodule : host_cpu_model

/* cpu_host_access_port_tb.sv */
// Purpose: Self-checking bench for the host access port.
// Assumes: Core-side inputs are driven directly by the bench.
// Notes:   Host strobes, address and data come from host_cpu_model; the bench drives i_mode_8bit.
module cpu_host_access_port_tb
    import cpu_host_access_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        i_clk, i_rstn, i_mode_8bit, i_cs_n, i_wr_n, i_rd_n, i_timeout_evt;
    logic [2:0]  i_addr, irq;
    logic [15:0] i_wdata, o_rdata, i_txf_data, o_crx_wdata, i_ctx1_data, i_ctx2_data, q;
    logic [7:0]  i_ind_rdata;
    logic [5:0]  st;
    ind_req_t    o_ind;
    rxf_word_t   o_rxf_word;
    logic        i_txf_has_data, i_txf_eof, i_rxf_space_ok, i_crx_free, i_ctx1_avail, i_ctx2_avail;
    logic        i_irq_frame, i_irq_cf1, i_irq_cf2, o_txf_pop, o_txf_done, o_rxf_valid, o_realign;
    logic        o_crx_we, o_crx_ready, o_ctx1_pop, o_ctx2_pop, o_ctx1_release, o_ctx2_release;
    int          error_cnt, checks_done, cyc, pc[9];
    int          cb[5] = '{0, 1, 2, 3, 5};
    // One-cycle pulses counted over the whole run; each must fire exactly once
    wire [8:0]   pl = {o_crx_we, o_ctx2_pop, o_ctx1_pop, o_txf_pop,
                       o_realign, o_txf_done, o_ctx2_release, o_ctx1_release, o_crx_ready};

    assign {i_txf_eof, i_rxf_space_ok, i_txf_has_data, i_ctx2_avail, i_ctx1_avail, i_crx_free} = st;
    assign {i_irq_cf2, i_irq_cf1, i_irq_frame} = irq;

    cpu_host_access_port dut_u (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_mode_8bit(i_mode_8bit), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n),
        .i_rd_n(i_rd_n), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_ind(o_ind),
        .i_ind_rdata(i_ind_rdata), .i_txf_data(i_txf_data), .i_txf_has_data(i_txf_has_data),
        .i_txf_eof(i_txf_eof), .o_txf_pop(o_txf_pop), .o_txf_done(o_txf_done), .i_rxf_space_ok(i_rxf_space_ok),
        .o_rxf_word(o_rxf_word), .o_rxf_valid(o_rxf_valid), .o_realign(o_realign), .i_crx_free(i_crx_free),
        .o_crx_wdata(o_crx_wdata), .o_crx_we(o_crx_we), .o_crx_ready(o_crx_ready), .i_ctx1_avail(i_ctx1_avail),
        .i_ctx2_avail(i_ctx2_avail), .i_ctx1_data(i_ctx1_data), .i_ctx2_data(i_ctx2_data),
        .o_ctx1_pop(o_ctx1_pop), .o_ctx2_pop(o_ctx2_pop), .o_ctx1_release(o_ctx1_release),
        .o_ctx2_release(o_ctx2_release), .i_irq_frame(i_irq_frame), .i_irq_cf1(i_irq_cf1),
        .i_irq_cf2(i_irq_cf2), .i_timeout_evt(i_timeout_evt));

    host_cpu_model host_u (.i_clk(i_clk), .i_rdata(o_rdata), .o_cs_n(i_cs_n), .o_wr_n(i_wr_n),
        .o_rd_n(i_rd_n), .o_addr(i_addr), .o_wdata(i_wdata));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        for (int k = 0; k < 9; k++) begin
            if (pl[k] === 1'b1) pc[k]++;
        end
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic w(input logic [2:0] a, input logic [15:0] d);
        host_u.acc(1'b1, a, d, q);
    endtask : w

    task automatic r(input logic [2:0] a);
        host_u.acc(1'b0, a, 16'h0000, q);
    endtask : r

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        i_rstn = 1'b0;
        i_mode_8bit = 1'b0;
        i_timeout_evt = 1'b0;
        i_ind_rdata = 8'hC7;
        i_txf_data = 16'h1E2D;
        i_ctx1_data = 16'h3C4B;
        i_ctx2_data = 16'h5A69;
        st = 6'h00;
        irq = 3'h0;
        repeat (20) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        for (int k = 0; k < 6; k++) begin
            st = 6'h01 << k;
            r(3'h4);
            chk("status", 32'(st), 32'(q));
        end
        $display("test status done");
        w(3'h0, 16'hA5C3);
        chk("index", 32'hA5C3, 32'(o_ind.addr));
        w(3'h1, 16'h0077);
        chk("index_hi_wide", 32'hA5C3, 32'(o_ind.addr));
        r(3'h0);
        chk("index_read", 32'h0, 32'(q));
        i_mode_8bit = 1'b1;
        w(3'h0, 16'hFF12);
        w(3'h1, 16'h0034);
        chk("index_8bit", 32'h3412, 32'(o_ind.addr));
        w(3'h2, 16'h005E);
        chk("ind_wdata", 32'h5E, 32'(o_ind.wdata));
        r(3'h2);
        chk("ind_rdata", 32'hC7, 32'(q));
        i_mode_8bit = 1'b0;
        $display("test indirect done");
        for (int k = 0; k < 7; k++) begin
            w(3'h3, 16'h0100 + 16'(k));
            chk("rx_word", {13'h0, 16'h0100 + 16'(k), 1'b1, 1'(k < 4), 1'b0}, 32'(o_rxf_word));
        end
        w(3'h4, 16'h0010);
        w(3'h3, 16'hBEEF);
        chk("rx_eof", 32'h5_F77D, 32'(o_rxf_word));
        w(3'h3, 16'h0001);
        chk("rx_next", 32'hE, 32'(o_rxf_word));
        $display("test frame done");
        r(3'h3);
        chk("txf_read", 32'h1E2D, 32'(q));
        st = 6'h06;
        r(3'h4);
        chk("tx_bufs_ready", 32'h06, 32'(q));
        r(3'h6);
        chk("buf1_read", 32'h3C4B, 32'(q));
        r(3'h7);
        chk("buf2_read", 32'h5A69, 32'(q));
        st = 6'h01;
        r(3'h4);
        chk("rx_buf_free", 32'h01, 32'(q));
        w(3'h6, 16'h6A7B);
        chk("crx_wdata", 32'h6A7B, 32'(o_crx_wdata));
        w(3'h7, 16'h1111);
        chk("buf2_write", 32'h6A7B, 32'(o_crx_wdata));
        // Arm end of frame, then the realign command in the loop must disarm it
        w(3'h4, 16'h0010);
        foreach (cb[k]) w(3'h4, 16'h0001 << cb[k]);
        foreach (pc[k]) chk("pulse_count", 32'h1, 32'(pc[k]));
        w(3'h3, 16'h0003);
        chk("rx_realigned", 32'h1E, 32'(o_rxf_word));
        $display("test buffers done");
        irq = 3'h5;
        i_timeout_evt = 1'b1;
        @(posedge i_clk);
        #1;
        i_timeout_evt = 1'b0;
        r(3'h5);
        chk("irq", 32'h85, 32'(q));
        r(3'h5);
        chk("irq_sticky", 32'h85, 32'(q));
        w(3'h5, 16'h007F);
        r(3'h5);
        chk("irq_clear", 32'h05, 32'(q));
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule : cpu_host_access_port_tb

bind cpu_host_access_port cpu_host_access_port_props props_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_mode_8bit(i_mode_8bit), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n),
    .i_rd_n(i_rd_n), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_ind(o_ind),
    .o_rxf_valid(o_rxf_valid), .o_crx_we(o_crx_we), .o_crx_ready(o_crx_ready), .o_txf_done(o_txf_done));
